// *** rtl/sd_tuning_pkg.sv ***
package sd_tuning_pkg;

  // ==========================================================================
  // register map, word indices on the plain port
  // ==========================================================================
  localparam logic [7:0] host_control_two_offset     = 8'h3e;
  localparam logic [7:0] capability_word_zero_offset = 8'h40;
  localparam logic [7:0] tuning_status_offset        = 8'h48;
  localparam logic [7:0] preset_drive_offset         = 8'h4c;

  // ==========================================================================
  // host_control_two fields
  // ==========================================================================
  localparam int preset_apply_bit   = 15;
  localparam int sample_select_bit  = 7;
  localparam int tuning_launch_bit  = 6;
  localparam int drive_hi           = 5;
  localparam int drive_lo           = 4;
  localparam int low_voltage_bit    = 3;
  localparam int speed_hi           = 2;
  localparam int speed_lo           = 0;

  // fixed capability word: 31:30=00, 29=1, 28=0, 27=0, 26..24=1, 23=1,
  // 22=1, 21=1, 20=0, 19=1, 18=0, 17:16=10, 15:8=00, 7=1, 6=0, 5:0=01
  localparam logic [31:0] capability_word_zero_value = 32'h27ea0081;

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam int          sys_clk_mhz        = 10;
  localparam int          tuning_time_us     = 150;
  localparam int          tuning_cycles      = tuning_time_us * sys_clk_mhz;
  localparam int          tuning_edges       = 40;
  localparam logic [11:0] tuning_cycles_w    = 12'(tuning_cycles);
  localparam logic [5:0]  tuning_edges_w     = 6'(tuning_edges);

  // ==========================================================================
  // encodings
  // ==========================================================================
  typedef enum logic [1:0] {drive_b, drive_a, drive_c, drive_d} drive_type_t;

  typedef enum logic [2:0] {
    speed_sdr12   = 3'h0,
    speed_sdr25   = 3'h1,
    speed_sdr50   = 3'h2,
    speed_sdr104  = 3'h3,
    speed_ddr50   = 3'h4
  } speed_code_t;

  typedef enum {tune_idle, tune_run} tune_state_t;

  typedef struct packed {
    logic       preset_apply;
    logic       sample_select;
    logic       tuning_launch;
    logic [1:0] drive_select;
    logic       low_voltage_signaling;
    logic [2:0] speed_select;
  } host_ctl_t;

  typedef struct packed {
    logic       low_voltage_signaling;
    logic [1:0] drive_type;
    logic       drive_active;
    logic       sdr12;
    logic       sdr25;
    logic       sdr50;
    logic       ddr50;
    logic       speed_invalid;
    logic       use_tuned_clock;
    logic       tuning_busy;
  } bus_ctl_t;

endpackage

// *** rtl/sd_host_tuning_signal_control.sv ***
// Contract
// - writing 1 to tuning launch starts the sampling-point tuning procedure.
// - hardware clears tuning launch when tuning finishes; 0 means done or never run.
// - writing 0 to tuning launch while set aborts the running tuning.
// - when tuning launch falls, hardware updates the sample clock choice bit.
// - sample with tuned clock when choice bit is 1, fixed clock when 0.
// - drive select ignored under 3.3V signaling, applied only under 1.8V.
// - drive select 00 type B, 01 type A, 10 type C, 11 type D.
// - preset apply 0 means software sets drive; 1 means hardware loads preset.
// - low voltage bit 1 selects 1.8V signaling, 0 selects 3.3V; supply stays 3.3V.
// - speed mode select is used only while low voltage signaling is set.
// - speed codes SDR12, SDR25, SDR50, DDR50; SDR104 unsupported; 101-111 reserved.
// - capability bits 31:30 read 00, single removable slot.
// - capability bit 29 reads 1, asynchronous interrupts supported, read-only.
// - capability bit 28 reads 0, no 64-bit system bus.
// - capability bit 23 reads 1, suspend and resume supported.
// - with preset apply set, hardware also loads clock frequency and generator select.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module sd_host_tuning_signal_control
  import sd_tuning_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata,
  input  wire logic        link_clk,
  input  wire logic        sample_point_ok,
  input  wire logic        rx_busy,
  input  wire logic [1:0]  preset_drive,
  input  wire logic [9:0]  preset_clk_freq,
  input  wire logic        preset_clk_gen,
  output bus_ctl_t         bus_ctl,
  output logic      [9:0]  clk_freq_select,
  output logic             clk_gen_select,
  output logic             preset_loaded
);

  // ==========================================================================
  // state
  // ==========================================================================
  typedef struct packed {
    host_ctl_t   ctl;
    tune_state_t tune;
    logic [11:0] tune_timer;
    logic [5:0]  good_edges;
    logic        tune_pass;
    logic        tune_aborted;
    logic        clr_blocked;
    logic [2:0]  link_sync;
    logic        ok_meta;
    logic        ok_sync;
    logic        busy_meta;
    logic        busy_sync;
    bus_ctl_t    bus;
    logic [9:0]  clk_freq;
    logic        clk_gen;
    logic        preset_done;
    logic [31:0] rdata;
  } state_t;

  state_t cur;
  state_t next_cur;

  logic host_write;
  logic link_rise;
  logic [31:0] host_rd;

  // ==========================================================================
  // decode helpers
  // ==========================================================================
  // only the second and third link stages feed the edge detector, first stays isolated
  assign link_rise  = cur.link_sync[1] & ~cur.link_sync[2];
  assign host_write = reg_write && (reg_addr == host_control_two_offset);

  // host_control_two read image, reserved bits read zero
  always_comb
  begin
    host_rd                    = '0;
    host_rd[preset_apply_bit]  = cur.ctl.preset_apply;
    host_rd[sample_select_bit] = cur.ctl.sample_select;
    host_rd[tuning_launch_bit] = cur.ctl.tuning_launch;
    host_rd[drive_hi:drive_lo] = cur.ctl.drive_select;
    host_rd[low_voltage_bit]   = cur.ctl.low_voltage_signaling;
    host_rd[speed_hi:speed_lo] = cur.ctl.speed_select;
  end

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb
  begin
    next_cur = cur;

    // pins cross into sys_clk through two flops before use
    next_cur.link_sync = {cur.link_sync[1:0], link_clk};
    next_cur.ok_meta   = sample_point_ok;
    next_cur.ok_sync   = cur.ok_meta;
    next_cur.busy_meta = rx_busy;
    next_cur.busy_sync = cur.busy_meta;

    // software writes; launch and sample bits handled below
    if (host_write)
    begin
      next_cur.ctl.preset_apply          = reg_wdata[preset_apply_bit];
      next_cur.ctl.low_voltage_signaling = reg_wdata[low_voltage_bit];
      next_cur.ctl.speed_select          = reg_wdata[speed_hi:speed_lo];
      if (!reg_wdata[preset_apply_bit])
      begin
        next_cur.ctl.drive_select = reg_wdata[drive_hi:drive_lo];
      end
      // a clear is honoured only when the receive path is quiet
      if (!reg_wdata[sample_select_bit])
      begin
        if (!cur.busy_sync)
        begin
          next_cur.ctl.sample_select = 1'b0;
        end
        else
        begin
          next_cur.clr_blocked = 1'b1;
        end
      end
      // a written 1 is dropped: only hardware sets the choice bit
    end

    // preset loading, re-applied every cycle while enabled
    next_cur.preset_done = 1'b0;
    if (next_cur.ctl.preset_apply)
    begin
      next_cur.ctl.drive_select = preset_drive;
      next_cur.clk_freq         = preset_clk_freq;
      next_cur.clk_gen          = preset_clk_gen;
      next_cur.preset_done      = 1'b1;
    end

    // tuning sequencer
    case (cur.tune)
      tune_idle:
      begin
        if (host_write && reg_wdata[tuning_launch_bit])
        begin
          next_cur.ctl.tuning_launch = 1'b1;
          next_cur.tune              = tune_run;
          next_cur.tune_timer        = '0;
          next_cur.good_edges        = '0;
          next_cur.tune_pass         = 1'b0;
          next_cur.tune_aborted      = 1'b0;
        end
      end
      tune_run:
      begin
        next_cur.tune_timer = cur.tune_timer + 12'h001;
        // count link edges where the sample point looked good
        if (link_rise && cur.ok_sync && cur.good_edges != tuning_edges_w)
        begin
          next_cur.good_edges = cur.good_edges + 6'h01;
        end
        if (host_write && !reg_wdata[tuning_launch_bit])
        begin
          // abort leaves the fixed clock in use
          next_cur.ctl.tuning_launch = 1'b0;
          next_cur.ctl.sample_select = 1'b0;
          next_cur.tune_aborted      = 1'b1;
          next_cur.tune              = tune_idle;
        end
        else if (cur.good_edges == tuning_edges_w)
        begin
          next_cur.ctl.tuning_launch = 1'b0;
          next_cur.ctl.sample_select = 1'b1;
          next_cur.tune_pass         = 1'b1;
          next_cur.tune              = tune_idle;
        end
        else if (cur.tune_timer == tuning_cycles_w - 12'h001)
        begin
          // timeout: no window found, fall back to the fixed clock
          next_cur.ctl.tuning_launch = 1'b0;
          next_cur.ctl.sample_select = 1'b0;
          next_cur.tune              = tune_idle;
        end
      end
      default:
      begin
        next_cur.tune = tune_idle;
      end
    endcase

    // bus-facing decode, registered
    next_cur.bus.low_voltage_signaling = cur.ctl.low_voltage_signaling;
    next_cur.bus.drive_type            = cur.ctl.drive_select;
    next_cur.bus.drive_active          = cur.ctl.low_voltage_signaling;
    next_cur.bus.sdr12         = 1'b1;
    next_cur.bus.sdr25         = 1'b0;
    next_cur.bus.sdr50         = 1'b0;
    next_cur.bus.ddr50         = 1'b0;
    next_cur.bus.speed_invalid = 1'b0;
    // under 3.3V the speed field is disregarded and default speed holds
    if (cur.ctl.low_voltage_signaling)
    begin
      next_cur.bus.sdr12 = 1'b0;
      case (cur.ctl.speed_select)
        speed_sdr12: next_cur.bus.sdr12 = 1'b1;
        speed_sdr25: next_cur.bus.sdr25 = 1'b1;
        speed_sdr50: next_cur.bus.sdr50 = 1'b1;
        speed_ddr50: next_cur.bus.ddr50 = 1'b1;
        default:     next_cur.bus.speed_invalid = 1'b1;
      endcase
    end
    next_cur.bus.use_tuned_clock = cur.ctl.sample_select;
    next_cur.bus.tuning_busy     = cur.ctl.tuning_launch;

    // register read port, data one cycle after the strobe
    next_cur.rdata = '0;
    if (reg_read)
    begin
      if (reg_addr == host_control_two_offset)
      begin
        next_cur.rdata = host_rd;
      end
      else if (reg_addr == capability_word_zero_offset)
      begin
        next_cur.rdata = capability_word_zero_value;
      end
      else if (reg_addr == tuning_status_offset)
      begin
        next_cur.rdata = {22'h000000, cur.clr_blocked, cur.tune_aborted,
                          cur.tune_pass, cur.good_edges, cur.ctl.tuning_launch};
      end
      else if (reg_addr == preset_drive_offset)
      begin
        next_cur.rdata = {19'h00000, cur.clk_gen, cur.clk_freq, preset_drive};
      end
    end
    // reading status clears the sticky blocked flag unless set again now
    if (reg_read && reg_addr == tuning_status_offset && !next_cur.clr_blocked)
    begin
      next_cur.clr_blocked = 1'b0;
    end
    else if (reg_read && reg_addr == tuning_status_offset && cur.clr_blocked &&
             !(host_write && !reg_wdata[sample_select_bit] && cur.busy_sync))
    begin
      next_cur.clr_blocked = 1'b0;
    end
  end

  // ==========================================================================
  // registers
  // ==========================================================================
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cur <= '0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // outputs
  assign reg_rdata       = cur.rdata;
  assign bus_ctl         = cur.bus;
  assign clk_freq_select = cur.clk_freq;
  assign clk_gen_select  = cur.clk_gen;
  assign preset_loaded   = cur.preset_done;

endmodule

`default_nettype wire

// *** verification/sd_card_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// card side of the tuning link
// ==========================================================================
module sd_card_model
(
  input  wire logic run,
  input  wire logic good,
  output logic      link_clk,
  output logic      sample_point_ok
);
  initial link_clk = 1'b0;
  initial sample_point_ok = 1'b0;
  // 800 ns link clock only inside a tuning frame; it stands still between frames
  always
  begin
    #400;
    if (run)
      link_clk = ~link_clk;
    else
      link_clk = 1'b0;
    // outside frames the verdict line wanders so a stale 1 never counts
    sample_point_ok = run ? good : ~sample_point_ok;
  end
endmodule
`default_nettype wire

// *** verification/sd_host_tuning_signal_control_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// port checks
// ==========================================================================
module sd_tuning_checker
  import sd_tuning_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_read,
  input wire logic [31:0] reg_rdata,
  input wire bus_ctl_t    bus_ctl,
  input wire logic [1:0]  preset_drive,
  input wire logic [9:0]  preset_clk_freq,
  input wire logic [9:0]  clk_freq_select,
  input wire logic        preset_loaded
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  localparam int tune_max = 1510;
  logic [11:0] busy_cycles;
  // a run may last the whole timeout, too long for a delay range, so count it
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      busy_cycles <= 12'h000;
    else if (bus_ctl.tuning_busy)
      busy_cycles <= busy_cycles + 12'h001;
    else
      busy_cycles <= 12'h000;
  end
  // decoded outputs only settle one edge after reset leaves
  property p_busy_ends; busy_cycles <= tune_max; endproperty
  a_busy_ends: assert property (p_busy_ends) else $error("tuning never ended");
  property p_cap; reg_read && reg_addr == 8'h40 |=> reg_rdata == capability_word_zero_value; endproperty
  a_cap: assert property (p_cap) else $error("capability word wrong");
  property p_idle_zero; !reg_read |=> reg_rdata == 32'h0; endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("read data outside its cycle");
  property p_unmapped; reg_read && !(reg_addr inside {8'h3e, 8'h40, 8'h48, 8'h4c}) |=> reg_rdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_drive_off; !$past(rst) && !bus_ctl.low_voltage_signaling |-> !bus_ctl.drive_active; endproperty
  a_drive_off: assert property (p_drive_off) else $error("drive applied at 3.3V");
  property p_speed_hv; !$past(rst) && !bus_ctl.low_voltage_signaling |-> bus_ctl.sdr12 && !bus_ctl.speed_invalid; endproperty
  a_speed_hv: assert property (p_speed_hv) else $error("speed used at 3.3V");
  property p_onehot; !$past(rst) |-> $onehot({bus_ctl.sdr12, bus_ctl.sdr25, bus_ctl.sdr50, bus_ctl.ddr50, bus_ctl.speed_invalid}); endproperty
  a_onehot: assert property (p_onehot) else $error("speed decode not one-hot");
  property p_preset_freq; preset_loaded |-> clk_freq_select == $past(preset_clk_freq); endproperty
  a_preset_freq: assert property (p_preset_freq) else $error("preset frequency not loaded");
  property p_preset_drive; preset_loaded |=> bus_ctl.drive_type == $past(preset_drive, 2); endproperty
  a_preset_drive: assert property (p_preset_drive) else $error("preset drive not loaded");
endmodule
bind sd_host_tuning_signal_control sd_tuning_checker i_sd_tuning_checker (.sys_clk(sys_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_read(reg_read), .reg_rdata(reg_rdata), .bus_ctl(bus_ctl),
  .preset_drive(preset_drive), .preset_clk_freq(preset_clk_freq),
  .clk_freq_select(clk_freq_select), .preset_loaded(preset_loaded));
`default_nettype wire

// *** verification/sd_host_tuning_signal_control_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module sd_host_tuning_signal_control_tb
  import sd_tuning_pkg::*;
;
  logic sys_clk = 0, rst = 1, reg_write = 0, reg_read = 0, rx_busy = 0, run = 0, good = 1;
  logic [7:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, exp_q[$];
  logic link_clk, sample_point_ok, clk_gen_select, preset_loaded, rd_d = 0;
  logic [1:0] preset_drive = 2'h2, drv;
  logic preset_clk_gen = 1'b1;
  logic [9:0] preset_clk_freq = 10'h15a, clk_freq_select;
  logic [4:0] sp;
  bus_ctl_t bus_ctl;
  integer seed = 9, n_fail = 0, tests_run = 0, i;
  always #50 sys_clk = ~sys_clk;
  sd_card_model i_sd_card_model (.run(run), .good(good), .link_clk(link_clk),
    .sample_point_ok(sample_point_ok));
  sd_host_tuning_signal_control i_sd_host_tuning_signal_control (.sys_clk(sys_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .link_clk(link_clk), .sample_point_ok(sample_point_ok),
    .rx_busy(rx_busy), .preset_drive(preset_drive), .preset_clk_freq(preset_clk_freq),
    .preset_clk_gen(preset_clk_gen), .bus_ctl(bus_ctl), .clk_freq_select(clk_freq_select),
    .clk_gen_select(clk_gen_select), .preset_loaded(preset_loaded));
  // ==========================================================================
  // shared tasks
  // ==========================================================================
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // one-cycle strobe; a gap edge follows so the strobe is never set twice at once
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    if (w) reg_write <= 1'b1; else reg_read <= 1'b1;
    if (!w) exp_q.push_back(d);
    @(posedge sys_clk);
    reg_write <= 1'b0;
    reg_read <= 1'b0;
  endtask
  task settle;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  // bounded wait for the tuning run to finish
  task wait_idle;
    for (i = 0; i < 2000 && bus_ctl.tuning_busy !== 1'b0; i++) @(posedge sys_clk);
    if (i == 2000) begin n_fail++; give_verdict; end
  endtask
  // read data stand only in the cycle after the strobe
  always @(posedge sys_clk) rd_d <= reg_read;
  always @(negedge sys_clk) if (rd_d) check(reg_rdata, exp_q.pop_front());
  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    acc(1, 8'h40, $random(seed));
    acc(0, 8'h40, 32'h27ea0081);
    acc(0, 8'h10, 32'h0);
    // every speed code at both signaling levels, random drive type
    for (int k = 0; k < 16; k++)
    begin
      drv = $random(seed);
      acc(1, 8'h3e, {drv, k[3:0]});
      settle;
      sp = k[3] ? {k[2:0] == 0, k[2:0] == 1, k[2:0] == 2, k[2:0] == 4, k[2:0] == 3 || k[2:0] > 4}
                : 5'h10;
      check({bus_ctl.sdr12, bus_ctl.sdr25, bus_ctl.sdr50, bus_ctl.ddr50, bus_ctl.speed_invalid}, sp);
      check({bus_ctl.low_voltage_signaling, bus_ctl.drive_active}, {2{k[3]}});
      if (k[3]) check(bus_ctl.drive_type, drv);
    end
    // preset apply: written drive field loses to the preset one
    acc(1, 8'h3e, 32'h8038);
    settle;
    check({clk_gen_select, clk_freq_select}, {preset_clk_gen, preset_clk_freq});
    check(bus_ctl.drive_type, preset_drive);
    check(preset_loaded, 1'b1);
    acc(0, 8'h3e, 32'h8028);
    acc(0, 8'h4c, {19'h0, preset_clk_gen, preset_clk_freq, preset_drive});
    // tuning that passes
    acc(1, 8'h3e, 32'h0008);
    run <= 1'b1;
    acc(1, 8'h3e, 32'h0048);
    settle;
    check(bus_ctl.tuning_busy, 1'b1);
    check(preset_loaded, 1'b0);
    wait_idle;
    run <= 1'b0;
    settle;
    check(bus_ctl.use_tuned_clock, 1'b1);
    acc(0, 8'h3e, 32'h0088);
    // clearing the choice bit is refused while a receive is running
    rx_busy <= 1'b1;
    settle;
    acc(1, 8'h3e, 32'h0008);
    acc(0, 8'h3e, 32'h0088);
    // status shows the refused clear until it has been read once
    acc(0, 8'h48, {22'h0, 1'b1, 1'b0, 1'b1, tuning_edges_w, 1'b0});
    acc(0, 8'h48, {22'h0, 1'b0, 1'b0, 1'b1, tuning_edges_w, 1'b0});
    rx_busy <= 1'b0;
    settle;
    acc(1, 8'h3e, 32'h0008);
    acc(0, 8'h3e, 32'h0008);
    acc(1, 8'h3e, 32'h0088);
    acc(0, 8'h3e, 32'h0008);
    // abort in mid-run
    run <= 1'b1;
    acc(1, 8'h3e, 32'h0048);
    repeat (20) @(posedge sys_clk);
    acc(1, 8'h3e, 32'h0008);
    settle;
    check(bus_ctl.tuning_busy, 1'b0);
    acc(0, 8'h3e, 32'h0008);
    // no good edge at all, so the run times out with the fixed clock
    good <= 1'b0;
    acc(1, 8'h3e, 32'h0048);
    settle;
    wait_idle;
    run <= 1'b0;
    acc(0, 8'h3e, 32'h0008);
    settle;
    check(bus_ctl.use_tuned_clock, 1'b0);
    give_verdict;
  end
endmodule
`default_nettype wire
